// ### hdl/ssf_frame_engine.sv
// Serial frame-format engine: master or slave, three frame formats.
// Assumes FIFOs outside; config is stable while I_PORT_ENABLE_BIT is set.
// Functional notes
// R1: Words 4 to 16 bits, MSB first
// R2: Clock idles inactive, toggles only in frames
// R3: Idle clock plus pending receive data raises timeout
// R4: Frame select low through whole SPI/message frame
// R5: Pulsed format: frame high one period from rise
// R6: Pulsed format: launch on rise, sample on fall
// R7: Message format: 8-bit control, no receive then
// R8: Peer waits one clock, replies 4-16 bits
// R9: Pulsed idle: clock, frame low; transmit tristated
// R10: Pulsed: frame pulse loads word into shifter
// R11: Pulsed: MSB driven on rise after pulse
// R12: Pulsed: push receive word on next rise
// R13: SPI polarity sets idle clock level
// R14: SPI phase picks first or second sample edge
// R15: SPI idle: frame high, data low, clock driver
// R16: SPI start: frame low, then transmit driver on (master SPI drives transmit while idle too)
// R17: Phase clear: data half period, clock half later
// R18: Phase set: clock and data half period in
// R19: Polarity set phase clear: falling first, sample
// R20: Frame select rises one period after last sample
// R21: Phase clear back-to-back pulses frame select
// R22: Phase set back-to-back holds frame select low
// R23: Both set: falling first, sample on rising
// R24: Message idle: clock low, frame high, data low
// R25: Software disables port before changing config
`timescale 1ns/1ps
module ssf_frame_engine (
  // Clock and reset
  input  wire logic                         I_CLK_SYS,
  input  wire logic                         I_RST,
  // Configuration
  input  wire logic                         I_PORT_ENABLE_BIT,
  input  wire logic                         I_SLAVE_MODE,
  input  wire logic [1:0]                   I_FRAME_FORMAT,
  input  wire logic                         I_CLOCK_POLARITY,
  input  wire logic                         I_CLOCK_PHASE,
  input  wire logic [3:0]                   I_DATA_SIZE,
  input  wire logic [ssf_pkg::DIV_W-1:0]    I_HALF_DIV,
  // Transmit FIFO head
  input  wire logic                         I_TX_VALID,
  input  wire logic [ssf_pkg::WORD_W-1:0]   I_TX_DATA,
  output logic                              O_TX_POP,
  // Receive FIFO side
  output logic                              O_RX_PUSH,
  output logic [ssf_pkg::WORD_W-1:0]        O_RX_DATA,
  input  wire logic                         I_RX_NONEMPTY,
  output logic                              O_RX_TIMEOUT,
  output logic                              O_BUSY,
  // Serial pins
  input  wire logic                         I_SERIAL_CLOCK_PIN,
  output logic                              O_SERIAL_CLOCK_PIN,
  output logic                              O_SERIAL_CLOCK_PIN_OE,
  input  wire logic                         I_FRAME_SELECT_PIN,
  output logic                              O_FRAME_SELECT_PIN,
  output logic                              O_FRAME_SELECT_PIN_OE,
  output logic                              O_SERIAL_TX_PIN,
  output logic                              O_SERIAL_TX_PIN_OE,
  input  wire logic                         I_SERIAL_RX_PIN
);
  import ssf_pkg::*;

  // Slot to bit index: {valid, index}
  function automatic logic [4:0] slot_map(input logic [1:0] fmt,
                                          input logic [4:0] n,
                                          input logic [4:0] s,
                                          input logic       rx);
    logic [4:0] idx;
    logic       ok;
    idx = 5'h00;
    ok  = 1'b0;
    if (fmt == FMT_PULSE) begin
      ok  = (s != 5'h00);
      idx = n - s;
    end else if (fmt == FMT_MSG && !rx) begin
      ok  = (s < MSG_CTRL_SLOTS);
      idx = MSG_CTRL_SLOTS - 5'h01 - s;
    end else if (fmt == FMT_MSG) begin
      ok  = (s >= MSG_CTRL_SLOTS + MSG_WAIT_SLOTS);
      idx = n + MSG_CTRL_SLOTS + MSG_WAIT_SLOTS - 5'h01 - s;
    end else begin
      ok  = 1'b1;
      idx = n - 5'h01 - s;
    end
    return {ok, idx[3:0]};
  endfunction

  function automatic logic tx_bit(input logic [WORD_W-1:0] w,
                                  input logic [1:0]        fmt,
                                  input logic [4:0]        n,
                                  input logic [4:0]        s);
    logic [4:0] m;
    m = slot_map(fmt, n, s, 1'b0);
    return m[4] & w[m[3:0]];
  endfunction

  // Registers
  ssf_state_t         st_q;
  ssf_state_t         st_d;
  logic [4:0]         slot_q;
  logic [4:0]         slot_d;
  logic [1:0]         hold_q;
  logic [1:0]         hold_d;
  logic               c_q;
  logic               c_d;
  logic [WORD_W-1:0]  txw_q;
  logic [WORD_W-1:0]  rxsh_q;
  logic               push_pend_q;
  logic [7:0]         tmo_cnt_q;
  logic               clk_s1_q, clk_s2_q, clk_s3_q;
  logic               fss_s1_q, fss_s2_q, fss_s3_q;
  logic               rx_s1_q, rx_s2_q;

  // Configuration decode
  wire              en      = I_PORT_ENABLE_BIT;
  wire              master  = ~I_SLAVE_MODE;
  wire              fmt_spi = (I_FRAME_FORMAT == FMT_SPI);
  wire              fmt_ti  = (I_FRAME_FORMAT == FMT_PULSE);
  wire              fmt_msg = (I_FRAME_FORMAT == FMT_MSG);
  wire              pol     = fmt_spi & I_CLOCK_POLARITY;
  // Sample on logical rise: SPI phase clear, message format
  wire              sor     = (fmt_spi & ~I_CLOCK_PHASE) | fmt_msg; // see R14
  wire [3:0]        size_e  = (I_DATA_SIZE < SIZE_MIN) ? SIZE_MIN
                                                       : I_DATA_SIZE;
  wire [4:0]        nbits   = {1'b0, size_e} + 5'h01; // see R1
  wire [4:0]        nslots  = fmt_ti  ? nbits + 5'h01 :
                              fmt_msg ? nbits + MSG_CTRL_SLOTS
                                              + MSG_WAIT_SLOTS
                                      : nbits;
  wire              last    = (slot_q == nslots - 5'h01);
  wire [WORD_W-1:0] mask    = 16'hFFFF >> (WORD_BITS - nbits);

  // Edge events
  logic tick;
  wire  in_bits = (st_q == ST_BITS);
  wire  s_cur   = clk_s2_q ^ pol;
  wire  s_prev  = clk_s3_q ^ pol;
  wire  s_rise  = I_SLAVE_MODE & en & s_cur & ~s_prev;
  wire  s_fall  = I_SLAVE_MODE & en & ~s_cur & s_prev;
  wire  rise_ev = master ? (tick & in_bits & ~c_q) : s_rise;
  wire  fall_ev = master ? (tick & in_bits & c_q)  : s_fall;
  wire  adv     = master ? tick : (s_rise | s_fall);
  wire  slot_end = in_bits & fall_ev;
  wire  cap_ev  = in_bits & (sor ? rise_ev : fall_ev); // see R6
  wire [4:0] rx_m = slot_map(I_FRAME_FORMAT, nbits, slot_q, 1'b1);
  wire  cap_ok  = cap_ev & rx_m[4]; // see R7
  wire  cap_last = cap_ok & (rx_m[3:0] == 4'h0);
  wire [WORD_W-1:0] rx_next = {rxsh_q[WORD_W-2:0], rx_s2_q};

  // Frame start and continuation
  wire  s_fss_fell = fss_s3_q & ~fss_s2_q;
  wire  m_start = master & en & tick & I_TX_VALID
                & (st_q == ST_IDLE); // see R10 see R16
  wire  s_start = I_SLAVE_MODE & (st_q == ST_IDLE)
                & ((~fmt_ti & s_fss_fell) | (fmt_ti & s_rise & fss_s2_q));
  wire  s_abort = I_SLAVE_MODE & in_bits & ~fmt_ti & fss_s2_q;
  // Master: phase set, message and pulsed runs continue without a gap; slave: SPI and message runs continue while frame select stays low
  wire  cont    = master ? (en & I_TX_VALID
                            & (fmt_ti | fmt_msg | I_CLOCK_PHASE))
                         : (~fmt_ti & ~fss_s2_q); // see R21 see R22
  wire  cont_ev = slot_end & last & cont;
  wire  load_ev = m_start | s_start | cont_ev;
  wire [WORD_W-1:0] load_w = I_TX_VALID ? I_TX_DATA : '0;
  wire  setup_go = master & tick & (st_q == ST_SETUP);

  // Launch: rising-launch modes drive the slot's bit on rise
  wire  l_rise  = ~sor & in_bits & rise_ev; // see R11
  wire  l_fall  = sor & slot_end & ~last;
  wire  l_new   = sor & ((load_ev & (I_SLAVE_MODE | fmt_msg | cont_ev))
                         | setup_go); // see R17
  wire  tx_new  = setup_go ? txw_q[nbits[3:0] - 4'h1] : load_w[4'h0];
  wire  l_new_b = setup_go ? tx_new
                           : tx_bit(load_w, I_FRAME_FORMAT, nbits, 5'h00);
  wire  tx_lb   = l_new  ? l_new_b :
                  l_fall ? tx_bit(txw_q, I_FRAME_FORMAT, nbits,
                                  slot_q + 5'h01)
                         : tx_bit(txw_q, I_FRAME_FORMAT, nbits, slot_q);
  wire  launch  = l_new | l_fall | l_rise;

  // State machine
  always_comb begin
    st_d   = st_q;
    slot_d = slot_q;
    hold_d = hold_q;
    unique case (st_q)
      ST_IDLE: begin
        slot_d = 5'h00;
        if (m_start) begin
          st_d = (fmt_spi & ~I_CLOCK_PHASE) ? ST_SETUP : ST_BITS; // see R18
        end else if (s_start) begin
          st_d = ST_BITS;
        end
      end
      ST_SETUP: begin
        if (setup_go) begin
          st_d = ST_BITS;
        end
      end
      ST_BITS: begin
        if (s_abort) begin
          st_d = ST_IDLE;
        end else if (slot_end && last && cont) begin
          slot_d = 5'h00;
        end else if (slot_end && last) begin
          st_d   = master ? ST_HOLD : ST_IDLE;
          hold_d = sor ? HOLD_AFTER_RISE : HOLD_AFTER_FALL; // see R20
        end else if (slot_end) begin
          slot_d = slot_q + 5'h01;
        end
      end
      ST_HOLD: begin
        if (tick && hold_q == 2'h1) begin
          st_d = ST_IDLE;
        end else if (tick) begin
          hold_d = hold_q - 2'h1;
        end
      end
    endcase
    if (!en) begin
      st_d = ST_IDLE;
    end
  end

  // Pin values, from next state so they line up with it
  wire  idle_d  = (st_d == ST_IDLE);
  assign c_d    = (st_d == ST_BITS) & (c_q ^ (rise_ev | fall_ev)); // see R2
  wire  sclk_d  = c_d ^ pol; // see R13 see R19 see R23
  wire  fss_d   = fmt_ti ? ((st_d == ST_BITS) &
                            (rise_ev ? (slot_q == 5'h00)
                                     : O_FRAME_SELECT_PIN)) // see R5
                         : idle_d; // see R4 see R15 see R24
  wire  tx_d    = idle_d ? 1'b0 : (launch ? tx_lb : O_SERIAL_TX_PIN);
  wire  tx_oe_d = ~idle_d | (en & master & ~fmt_ti); // see R9 see R16
  wire  clk_oe_d = en & master; // see R15
  wire  tmo_run = (st_q == ST_IDLE) & I_RX_NONEMPTY; // see R3
  wire  tmo_hit = (tmo_cnt_q == TIMEOUT_HALF);
  wire [7:0] tmo_cnt_d = !tmo_run ? 8'h00 :
                         (tmo_hit ? tmo_cnt_q : tmo_cnt_q + {7'h00, tick});

  ssf_half_tick #(
    .DW         (DIV_W)
  ) u_tick (
    .i_clk      (I_CLK_SYS),
    .i_rst      (I_RST),
    .i_run      (en),
    .i_half_div (I_HALF_DIV),
    .o_tick     (tick)
  );

  // Pin synchronisers
  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      {clk_s1_q, clk_s2_q, clk_s3_q} <= 3'h0;
      {fss_s1_q, fss_s2_q, fss_s3_q} <= 3'h7;
      {rx_s1_q, rx_s2_q}             <= 2'h0;
    end else begin
      {clk_s1_q, clk_s2_q, clk_s3_q} <= {I_SERIAL_CLOCK_PIN, clk_s1_q,
                                         clk_s2_q};
      {fss_s1_q, fss_s2_q, fss_s3_q} <= {I_FRAME_SELECT_PIN, fss_s1_q,
                                         fss_s2_q};
      {rx_s1_q, rx_s2_q}             <= {I_SERIAL_RX_PIN, rx_s1_q};
    end
  end

  // Sequencer
  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      st_q   <= ST_IDLE;
      slot_q <= 5'h00;
      hold_q <= 2'h0;
      c_q    <= 1'b0;
      txw_q  <= '0;
      rxsh_q <= '0;
    end else begin
      st_q   <= st_d;
      slot_q <= slot_d;
      hold_q <= hold_d;
      c_q    <= c_d;
      if (load_ev) txw_q <= load_w; // see R10
      if (cap_ok) rxsh_q <= rx_next; // see R1
    end
  end

  // FIFO side and timeout
  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      O_TX_POP     <= 1'b0;
      O_RX_PUSH    <= 1'b0;
      O_RX_DATA    <= '0;
      push_pend_q  <= 1'b0;
      tmo_cnt_q    <= 8'h00;
      O_RX_TIMEOUT <= 1'b0;
      O_BUSY       <= 1'b0;
    end else begin
      O_TX_POP     <= load_ev & I_TX_VALID;
      O_RX_PUSH    <= push_pend_q & adv; // see R12
      if (cap_last) O_RX_DATA <= rx_next & mask;
      push_pend_q  <= cap_last | (push_pend_q & ~adv);
      tmo_cnt_q    <= tmo_cnt_d;
      O_RX_TIMEOUT <= tmo_run & tmo_hit;
      O_BUSY       <= ~idle_d;
    end
  end

  // Pins
  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      O_SERIAL_CLOCK_PIN    <= 1'b0;
      O_SERIAL_CLOCK_PIN_OE <= 1'b0;
      O_FRAME_SELECT_PIN    <= 1'b1;
      O_FRAME_SELECT_PIN_OE <= 1'b0;
      O_SERIAL_TX_PIN       <= 1'b0;
      O_SERIAL_TX_PIN_OE    <= 1'b0;
    end else begin
      O_SERIAL_CLOCK_PIN    <= sclk_d;
      O_SERIAL_CLOCK_PIN_OE <= clk_oe_d;
      O_FRAME_SELECT_PIN    <= fss_d;
      O_FRAME_SELECT_PIN_OE <= clk_oe_d;
      O_SERIAL_TX_PIN       <= tx_d;
      O_SERIAL_TX_PIN_OE    <= tx_oe_d;
    end
  end

  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (I_RST);

  AST_IDLE_CLK: assert property ( // see R13
    (st_q == ST_IDLE && $stable(pol)) |-> (O_SERIAL_CLOCK_PIN == pol))
    else $error("Serial clock not at idle level");
  AST_PULSE_ON_RISE: assert property ( // see R5
    (fmt_ti && master && $rose(O_FRAME_SELECT_PIN)) |->
      (O_SERIAL_CLOCK_PIN && $rose(O_SERIAL_CLOCK_PIN)))
    else $error("Frame pulse did not start on a rising edge");
  AST_SPI_FSS_LOW: assert property ( // see R4
    (master && !fmt_ti && (st_q == ST_BITS)) |-> !O_FRAME_SELECT_PIN)
    else $error("Frame select high inside a frame");
  AST_SIZE_RANGE: assert property ( // see R1
    load_ev |-> (nbits >= 5'h04 && nbits <= WORD_BITS))
    else $error("Word size out of range");
  AST_MSG_NO_RX: assert property ( // see R7
    (fmt_msg && cap_ok) |->
      (slot_q >= MSG_CTRL_SLOTS + MSG_WAIT_SLOTS))
    else $error("Receive during control message");
  AST_PUSH_NEXT_EDGE: assert property ( // see R12
    (push_pend_q && adv) |=> O_RX_PUSH)
    else $error("Received word not pushed on next edge");
  AST_TIMEOUT_IDLE: assert property ( // see R3
    O_RX_TIMEOUT |-> $past(st_q == ST_IDLE) && $past(I_RX_NONEMPTY))
    else $error("Timeout raised while not idle");
  AST_SLAVE_NO_CLK: assert property ( // see R15
    I_SLAVE_MODE |=> !O_SERIAL_CLOCK_PIN_OE)
    else $error("Slave drives serial clock");
  AST_TX_IDLE_LOW: assert property ( // see R24
    (st_q == ST_IDLE && !fmt_ti) |-> !O_SERIAL_TX_PIN)
    else $error("Transmit line not low while idle");
  AST_PULSE_IDLE_Z: assert property ( // see R9
    (st_q == ST_IDLE && fmt_ti) |-> !O_SERIAL_TX_PIN_OE)
    else $error("Transmit driven while pulsed format idle");

endmodule

// ### hdl/ssf_pkg.sv
// Constants and types for the serial frame-format engine.
// Assumes a 16-bit word path and one system clock.
package ssf_pkg;

  // Word and size limits
  localparam int         WORD_W    = 16;
  localparam logic [3:0] SIZE_MIN  = 4'h3;
  localparam logic [4:0] WORD_BITS = 5'h10;

  // Frame formats
  localparam logic [1:0] FMT_SPI   = 2'h0;
  localparam logic [1:0] FMT_PULSE = 2'h1;
  localparam logic [1:0] FMT_MSG   = 2'h2;

  // Half-duplex message layout, in slots
  localparam logic [4:0] MSG_CTRL_SLOTS = 5'h08;
  localparam logic [4:0] MSG_WAIT_SLOTS = 5'h01;

  // End-of-frame hold, in half periods after the last slot ends
  localparam logic [1:0] HOLD_AFTER_RISE = 2'h1;
  localparam logic [1:0] HOLD_AFTER_FALL = 2'h2;

  // Receive timeout, in serial bit periods while idle
  localparam int         TIMEOUT_BITS = 32;
  localparam logic [7:0] TIMEOUT_HALF = 8'(2 * TIMEOUT_BITS);

  // Divider width
  localparam int DIV_W = 16;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_SETUP = 4'b0010,
    ST_BITS  = 4'b0100,
    ST_HOLD  = 4'b1000
  } ssf_state_t;

endpackage

// ### hdl/ssf_half_tick.sv
// Half serial period enable divider.
// Assumes i_half_div counts system clocks per half period; 0 acts as 1.
`timescale 1ns/1ps
module ssf_half_tick #(
  parameter int DW = 16
) (
  // Clock and reset
  input  wire logic          i_clk,
  input  wire logic          i_rst,
  // Control
  input  wire logic          i_run,
  input  wire logic [DW-1:0] i_half_div,
  // Enable pulse
  output logic               o_tick
);

  logic [DW-1:0] cnt_q;
  logic [DW-1:0] cnt_d;
  logic          wrap;

  assign wrap  = (cnt_q + DW'(1)) >= i_half_div;
  assign cnt_d = (!i_run || wrap) ? '0 : cnt_q + DW'(1);

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_q  <= '0;
      o_tick <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      o_tick <= i_run && wrap;
    end
  end

endmodule

// ### verification/ssf_peer_model.sv
// Behavioural off-chip peer of the frame engine, in the slave role.
// Assumes the engine is master and drives clock and frame select.
`timescale 1ns/1ps
module ssf_peer_model (
  // Serial pins
  input  wire logic        i_sclk,
  input  wire logic        i_fss,
  input  wire logic        i_mosi,
  output logic             o_miso,
  // Configuration
  input  wire logic [1:0]  i_fmt,
  input  wire logic        i_cpol,
  input  wire logic        i_cpha,
  input  wire logic [4:0]  i_nbits,
  input  wire logic [15:0] i_reply
);
  import ssf_pkg::*;
  logic [15:0] got_q[$];
  logic [15:0] rsh     = 16'h0000;
  logic [15:0] cur     = 16'h0000;
  logic        fss_mid = 1'b0;
  logic        rcv     = 1'b0;
  logic        act     = 1'b0;
  int          t       = 0;
  int          r       = 0;
  int          k       = 0;
  int          words   = 0;
  wire         spi     = (i_fmt != FMT_PULSE) && (i_fmt != FMT_MSG);

  initial o_miso = 1'b0;

  // Launch next reply bit, MSB first
  task automatic drive();
    int idx;
    if (t == 0) cur = i_reply + 16'(words);
    idx = int'(i_nbits) - 1 - t;
    o_miso = cur[idx];
    t = (t + 1 == int'(i_nbits)) ? 0 : t + 1;
  endtask

  // Capture one master bit
  task automatic sample();
    rsh = {rsh[14:0], i_mosi};
    r = r + 1;
    if (r == int'(i_nbits)) begin
      got_q.push_back(rsh & ((16'h0001 << i_nbits) - 16'h0001));
      r = 0;
      words++;
    end
  endtask

  always @(negedge i_fss) begin
    t = 0;
    r = 0;
    k = 0;
    if (spi && !i_cpha) drive();
  end

  // Released line shows the inverse of the last bit
  always @(posedge i_fss) begin
    o_miso = ~o_miso;
    if (i_fmt == FMT_MSG) words++;
  end

  always @(i_sclk) begin
    if (spi && !i_fss) begin
      if ((i_sclk != i_cpol) ^ i_cpha) sample();
      else drive();
    end else if (i_fmt == FMT_PULSE && i_sclk) begin
      if (fss_mid) begin
        act = 1'b1;
        rcv = 1'b1;
        t = 0;
      end
      if (act) drive();
      if (act && t == 0) act = 1'b0;
    end else if (i_fmt == FMT_PULSE) begin
      if (rcv) begin
        sample();
        rcv = (r != 0);
      end
      fss_mid = i_fss;
    end else if (i_fmt == FMT_MSG && !i_fss) begin
      if (i_sclk) begin
        k++;
        if (k <= 8) rsh = {rsh[14:0], i_mosi};
        if (k == 8) got_q.push_back(rsh & 16'h00FF);
      end else if (k >= 9 && k < 9 + int'(i_nbits)) begin
        drive();
      end
    end
  end
endmodule

// ### verification/sync_serial_frame_formats_tb.sv
// Self-checking bench for the frame engine as master, with a peer model.
// Assumes the engine package is compiled first.
`timescale 1ns/1ps
module sync_serial_frame_formats_tb;
  import ssf_pkg::*;
  localparam int HDIV = 4;
  logic I_CLK_SYS = 1'b0, I_RST = 1'b1, I_PORT_ENABLE_BIT = 1'b0;
  logic I_SLAVE_MODE = 1'b0, I_CLOCK_POLARITY = 1'b0, I_CLOCK_PHASE = 1'b0;
  logic I_TX_VALID = 1'b0, I_RX_NONEMPTY = 1'b0, pat = 1'b0;
  logic [1:0]  I_FRAME_FORMAT = 2'h0;
  logic [3:0]  I_DATA_SIZE = 4'h7;
  logic [15:0] I_TX_DATA = 16'h0000, O_RX_DATA, reply = 16'h0000;
  logic [15:0] msk = 16'h00FF;
  logic [4:0]  nb = 5'h08;
  logic O_TX_POP, O_RX_PUSH, O_RX_TIMEOUT, O_BUSY, miso;
  logic O_SERIAL_CLOCK_PIN, O_SERIAL_CLOCK_PIN_OE, O_FRAME_SELECT_PIN;
  logic O_FRAME_SELECT_PIN_OE, O_SERIAL_TX_PIN, O_SERIAL_TX_PIN_OE;
  logic sck_p = 1'b0, fs_p = 1'b1;
  logic [15:0] exp_rx[$], exp_peer[$];
  int miscompares = 0, n_compared = 0, nexp = 0, n_sck = 0, n_fr = 0, n_fh = 0;
  wire sclk_w = O_SERIAL_CLOCK_PIN_OE ? O_SERIAL_CLOCK_PIN : 1'b0;
  wire fss_w  = O_FRAME_SELECT_PIN_OE ? O_FRAME_SELECT_PIN : 1'b1;
  wire mosi_w = O_SERIAL_TX_PIN_OE ? O_SERIAL_TX_PIN : pat;

  always #12.5 I_CLK_SYS = ~I_CLK_SYS;
  always @(posedge I_CLK_SYS) pat <= ~pat;

  ssf_frame_engine u_ssf_frame_engine (
    .I_CLK_SYS(I_CLK_SYS), .I_RST(I_RST),
    .I_PORT_ENABLE_BIT(I_PORT_ENABLE_BIT), .I_SLAVE_MODE(I_SLAVE_MODE),
    .I_FRAME_FORMAT(I_FRAME_FORMAT), .I_CLOCK_POLARITY(I_CLOCK_POLARITY),
    .I_CLOCK_PHASE(I_CLOCK_PHASE), .I_DATA_SIZE(I_DATA_SIZE),
    .I_HALF_DIV(16'(HDIV)), .I_TX_VALID(I_TX_VALID), .I_TX_DATA(I_TX_DATA),
    .O_TX_POP(O_TX_POP), .O_RX_PUSH(O_RX_PUSH), .O_RX_DATA(O_RX_DATA),
    .I_RX_NONEMPTY(I_RX_NONEMPTY), .O_RX_TIMEOUT(O_RX_TIMEOUT),
    .O_BUSY(O_BUSY), .I_SERIAL_CLOCK_PIN(sclk_w),
    .O_SERIAL_CLOCK_PIN(O_SERIAL_CLOCK_PIN),
    .O_SERIAL_CLOCK_PIN_OE(O_SERIAL_CLOCK_PIN_OE),
    .I_FRAME_SELECT_PIN(fss_w), .O_FRAME_SELECT_PIN(O_FRAME_SELECT_PIN),
    .O_FRAME_SELECT_PIN_OE(O_FRAME_SELECT_PIN_OE),
    .O_SERIAL_TX_PIN(O_SERIAL_TX_PIN), .O_SERIAL_TX_PIN_OE(O_SERIAL_TX_PIN_OE),
    .I_SERIAL_RX_PIN(miso));

  ssf_peer_model u_ssf_peer_model (
    .i_sclk(sclk_w), .i_fss(fss_w), .i_mosi(mosi_w), .o_miso(miso),
    .i_fmt(I_FRAME_FORMAT), .i_cpol(I_CLOCK_POLARITY),
    .i_cpha(I_CLOCK_PHASE), .i_nbits(nb), .i_reply(reply));

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) begin
      @(posedge I_CLK_SYS);
      #1;
    end
  endtask

  // Received words, pin edge counts and frame-high cycles, sampled away from launch edge
  always @(negedge I_CLK_SYS) begin
    if (O_RX_PUSH === 1'b1)
      chk(O_RX_DATA & msk,
          exp_rx.size() ? exp_rx.pop_front() : 16'hxxxx);
    n_sck += int'(O_SERIAL_CLOCK_PIN === 1'b1 && !sck_p);
    n_fr += int'(O_FRAME_SELECT_PIN === 1'b1 && !fs_p);
    n_fh += int'(O_FRAME_SELECT_PIN === 1'b1);
    sck_p = O_SERIAL_CLOCK_PIN;
    fs_p = O_FRAME_SELECT_PIN;
  end

  task automatic run(input logic [1:0] f, input logic p, input logic h,
                     input logic [3:0] sz, input int nw);
    logic [15:0] d;
    int g;
    I_PORT_ENABLE_BIT = 1'b0;
    cyc(2);
    I_FRAME_FORMAT = f;
    I_CLOCK_POLARITY = p;
    I_CLOCK_PHASE = h;
    I_DATA_SIZE = sz;
    nb = 5'(sz) + 5'h01;
    msk = (16'h0001 << nb) - 16'h0001;
    reply = 16'($urandom);
    cyc(2);
    I_PORT_ENABLE_BIT = 1'b1;
    cyc(4);
    if (f == FMT_PULSE)
      chk({O_SERIAL_CLOCK_PIN, O_FRAME_SELECT_PIN,
           O_SERIAL_TX_PIN_OE}, 0);
    else if (f == FMT_MSG)
      chk({O_SERIAL_CLOCK_PIN, O_FRAME_SELECT_PIN,
           O_SERIAL_TX_PIN}, 2);
    else
      chk({O_SERIAL_CLOCK_PIN, O_FRAME_SELECT_PIN, O_SERIAL_TX_PIN,
           O_SERIAL_CLOCK_PIN_OE}, {p, 3'b101});
    n_sck = 0;
    n_fr = 0;
    n_fh = 0;
    for (int w = 0; w < nw; w++) begin
      d = 16'($urandom);
      I_TX_VALID = 1'b1;
      I_TX_DATA = d;
      exp_peer.push_back(f == FMT_MSG ? (d & 16'h00FF) : (d & msk));
      exp_rx.push_back((reply + 16'(nexp)) & msk);
      nexp++;
      g = 0;
      do begin
        cyc(1);
        g++;
      end while (O_TX_POP !== 1'b1 && g < 600);
      chk({15'h0, O_TX_POP}, 16'h0001);
    end
    I_TX_VALID = 1'b0;
    g = 0;
    do begin
      cyc(1);
      g++;
    end while (O_BUSY !== 1'b0 && g < 2000);
    cyc(24);
    chk(16'(exp_rx.size()), 0);
    while (exp_peer.size())
      chk(u_ssf_peer_model.got_q.size() ? u_ssf_peer_model.got_q.pop_front()
          : 16'hxxxx, exp_peer.pop_front());
    if (f == FMT_PULSE) begin
      chk(16'(n_fh), 16'(nw * 2 * HDIV));
    end else if (f == FMT_MSG) begin
      chk(16'(n_sck), 16'(9 + int'(nb)));
      chk(16'(n_fr), 1);
    end else begin
      chk(16'(n_sck), 16'(nw * int'(nb)));
      chk(16'(n_fr), h ? 1 : 16'(nw));
      chk({15'h0, O_SERIAL_CLOCK_PIN}, {15'h0, p});
    end
  endtask

  initial begin
    #(20000 * 25);
    miscompares++;
    conclude();
  end

  initial begin
    logic [3:0] sz;
    void'($urandom(32'he897));
    cyc(16);
    chk({O_FRAME_SELECT_PIN, O_TX_POP, O_RX_PUSH, O_BUSY, O_RX_TIMEOUT,
         O_SERIAL_CLOCK_PIN_OE, O_SERIAL_TX_PIN_OE}, 16'h0040);
    I_RST = 1'b0;
    cyc(2);
    for (int j = 0; j < 3; j++) begin
      sz = (j == 0) ? 4'h3 : (j == 1) ? 4'hF : 4'(4 + $urandom_range(10));
      for (int m = 0; m < 4; m++)
        run(FMT_SPI, m[1], m[0], sz, 2);
      run(FMT_PULSE, 1'b0, 1'b0, sz, 2);
      run(FMT_MSG, 1'b0, 1'b0, sz, 1);
    end
    // Receive timeout while idle with pending data
    run(FMT_SPI, 1'b0, 1'b0, 4'h7, 1);
    I_RX_NONEMPTY = 1'b1;
    cyc(TIMEOUT_BITS * 2 * HDIV - 40);
    chk({15'h0, O_RX_TIMEOUT}, 0);
    cyc(80);
    chk({15'h0, O_RX_TIMEOUT}, 1);
    I_RX_NONEMPTY = 1'b0;
    cyc(4);
    chk({15'h0, O_RX_TIMEOUT}, 0);
    // Slave leaves clock and frame pads undriven
    I_PORT_ENABLE_BIT = 1'b0;
    cyc(2);
    I_SLAVE_MODE = 1'b1;
    cyc(2);
    I_PORT_ENABLE_BIT = 1'b1;
    cyc(4);
    chk({O_SERIAL_CLOCK_PIN_OE, O_FRAME_SELECT_PIN_OE}, 0);
    conclude();
  end
endmodule
